// File: core/can_pwr_pkg.sv
// constants for the can power, bring-up and interrupt control block
package can_pwr_pkg;
	localparam int RECESSIVE_RUN = 11;
	localparam int WARN_LIMIT = 96;
	localparam int INTERMISSION_WATCH = 2;
	localparam int NUM_MAILBOX = 16;
	localparam int TIMER_WIDTH = 16;
	localparam int ERR_WIDTH = 9;
	// status bit positions above the mailbox bits
	localparam int SR_ERRA = 16;
	localparam int SR_WARN = 17;
	localparam int SR_ERRP = 18;
	localparam int SR_BOFF = 19;
	localparam int SR_SLEEP = 20;
	localparam int SR_WAKEUP = 21;
	localparam int SR_TOVF = 22;
	localparam int SR_TSTP = 23;
	localparam int SR_WIDTH = 24;
	localparam logic [23:0] MASK_RESET = 24'h000000;
	localparam logic [3:0] RUN_RESET = 4'h0;
	typedef enum logic [1:0] {
		PWR_OFF,
		PWR_SYNC,
		PWR_RUN,
		PWR_DRAIN
	} pwr_state_t;
endpackage

// File: core/can_power_init_irq_control.sv
// power, bring-up, overload and interrupt control of a can controller
//
// Contract
// - dominant in first two intermission bits starts a reactive overload frame.
// - receiver dominant at last EOF or delimiter bit starts reactive overload.
// - with overload_request_enable, request overload after every delivered message.
// - reactive overload always; flagged like an error, counters unchanged.
// - in low power no transmit, no receive, mailboxes inactive.
// - sleep and wake flags exclusive; both zero after reset until an event.
// - after reset low power off; wake set after 11 recessive bits.
// - low_power_request waits for pending transmits, then sleeps and sets sleep.
// - reception off while sleep flag set; allowed before entry.
// - error counters disabled while sleep flag is one.
// - leaving low power resynchronises on eleven recessive bits, sets wake.
// - idle bus: transmit possible eleven bit times after request cleared.
// - busy bus: synchronise at next interframe, drop message in progress.
// - enable resets protocol engine, counters and error flags, then syncs.
// - autobaud listening freezes error counters while receiving.
// - enable/disable writes unmask/mask; mask readable; all masked at reset.
// - per-mailbox sources for new receive, sent, aborted.
// - sources for bus-off, passive, active, warning, wake, sleep.
// - frame start/end copies timer to timestamp; rollover raises overflow.
// - overflow and timestamp clear on status read; others follow condition.
// - warning while error active and a counter exceeds 96.
`timescale 1ns/100ps
`default_nettype none
module can_power_init_irq_control
	import can_pwr_pkg::*;
#(
	parameter int MB = NUM_MAILBOX,
	parameter int TW = TIMER_WIDTH
)(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// mode register bits
	input wire logic controller_enable,
	input wire logic low_power_request,
	input wire logic overload_request_enable,
	input wire logic autobaud_listen,
	// mask writes and status read
	input wire logic [SR_WIDTH-1:0] interrupt_enable_register,
	input wire logic [SR_WIDTH-1:0] interrupt_disable_register,
	input wire logic status_read,
	// protocol engine events, one per bit time unless stated
	input wire logic bit_tick,
	input wire logic bus_rx,
	input wire logic in_intermission,
	input wire logic [1:0] intermission_bit,
	input wire logic last_eof_bit,
	input wire logic last_delim_bit,
	input wire logic is_receiver,
	input wire logic frame_in_progress,
	input wire logic frame_edge,
	input wire logic message_delivered,
	input wire logic tx_pending,
	// fault confinement and mailbox sources
	input wire logic [ERR_WIDTH-1:0] tx_err_count,
	input wire logic [ERR_WIDTH-1:0] rx_err_count,
	input wire logic bus_off,
	input wire logic error_passive,
	input wire logic [MB-1:0] mailbox_ready,
	input wire logic [MB-1:0] mailbox_aborted,
	// control towards the protocol engine
	output logic overload_start,
	output logic overload_reactive,
	output logic protocol_reset,
	output logic tx_allowed,
	output logic rx_allowed,
	output logic mailboxes_active,
	output logic error_count_enable,
	output logic discard_frame,
	// status, masks and interrupt
	output logic [SR_WIDTH-1:0] status_register,
	output logic [SR_WIDTH-1:0] interrupt_mask_register,
	output logic [TW-1:0] timestamp_register,
	output logic irq
);
	pwr_state_t state;
	logic [3:0] recessive_run;
	logic enable_q;
	logic sleep_flag;
	logic wake_flag;
	logic tovf_flag;
	logic tstp_flag;
	logic [TW-1:0] timer;
	logic [SR_WIDTH-1:0] sources;
	logic sync_done;
	logic warn;
	logic enable_rise;

	assign enable_rise = controller_enable & ~enable_q;
	assign sync_done = bit_tick && bus_rx &&
		recessive_run == 4'(RECESSIVE_RUN - 1);

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			enable_q <= 1'b0;
		else
			enable_q <= controller_enable;
	end

	// counts recessive bits; a dominant bit restarts the run
	// held at zero while the request stands: a run that saturated
	// during sleep would otherwise never meet the compare value,
	// and the resync must count only bits seen after the clear
	always_ff @(posedge sys_clk)
	begin
		if (rst || state != PWR_SYNC || low_power_request)
			recessive_run <= RUN_RESET;
		else if (bit_tick)
		begin
			if (!bus_rx)
				recessive_run <= RUN_RESET;
			else if (recessive_run != 4'(RECESSIVE_RUN))
				recessive_run <= recessive_run + 4'h1;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			state <= PWR_OFF;
		else if (!controller_enable)
			state <= PWR_OFF;
		else if (enable_rise)
			state <= PWR_SYNC;
		else
		begin
			case (state)
				PWR_OFF:
					state <= PWR_SYNC;
				PWR_SYNC:
					if (sync_done && !low_power_request)
						state <= PWR_RUN;
				PWR_RUN:
					if (low_power_request)
						state <= PWR_DRAIN;
				PWR_DRAIN:
					if (!low_power_request)
						state <= PWR_RUN;
					else if (!tx_pending && !frame_in_progress)
						state <= PWR_OFF;
				default:
					state <= PWR_OFF;
			endcase
		end
	end

	// sleep entry is drain finished; request cleared from sleep resyncs
	always_ff @(posedge sys_clk)
	begin
		if (rst || enable_rise)
		begin
			sleep_flag <= 1'b0;
			wake_flag <= 1'b0;
		end
		else if (state == PWR_DRAIN && low_power_request &&
			!tx_pending && !frame_in_progress)
		begin
			sleep_flag <= 1'b1;
			wake_flag <= 1'b0;
		end
		else if (state == PWR_SYNC && sync_done && !low_power_request)
		begin
			wake_flag <= 1'b1;
			sleep_flag <= 1'b0;
		end
	end

	// a sleeping controller sits in sync until the request drops
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			discard_frame <= 1'b0;
		else
			discard_frame <= sleep_flag && !low_power_request &&
				frame_in_progress;
	end

	assign protocol_reset = enable_rise;
	// drain keeps transmit open, else pending frames could never leave
	assign tx_allowed = (state == PWR_RUN || state == PWR_DRAIN) &&
		!autobaud_listen && !sleep_flag;
	assign rx_allowed = (state == PWR_RUN || state == PWR_DRAIN) &&
		!sleep_flag;
	assign mailboxes_active = !sleep_flag && state != PWR_OFF;
	assign error_count_enable = !sleep_flag && !autobaud_listen &&
		state != PWR_OFF;

	// overload frames: reactive ones ignore the enable bit
	always_ff @(posedge sys_clk)
	begin
		if (rst || enable_rise)
		begin
			overload_start <= 1'b0;
			overload_reactive <= 1'b0;
		end
		else
		begin
			overload_start <= 1'b0;
			overload_reactive <= 1'b0;
			if (bit_tick && !bus_rx && rx_allowed &&
				((in_intermission &&
				intermission_bit < 2'(INTERMISSION_WATCH)) ||
				(last_eof_bit && is_receiver) || last_delim_bit))
			begin
				overload_start <= 1'b1;
				overload_reactive <= 1'b1;
			end
			else if (message_delivered && overload_request_enable &&
				rx_allowed)
				overload_start <= 1'b1;
		end
	end

	assign warn = !bus_off && !error_passive &&
		(tx_err_count > ERR_WIDTH'(WARN_LIMIT) ||
		rx_err_count > ERR_WIDTH'(WARN_LIMIT));

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			timer <= '0;
		else if (state != PWR_OFF)
			timer <= timer + TW'(1);
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			timestamp_register <= '0;
		else if (frame_edge)
			timestamp_register <= timer;
	end

	// a new event wins over the read that would clear it
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			tovf_flag <= 1'b0;
			tstp_flag <= 1'b0;
		end
		else
		begin
			if (state != PWR_OFF && timer == '1)
				tovf_flag <= 1'b1;
			else if (status_read)
				tovf_flag <= 1'b0;
			if (frame_edge)
				tstp_flag <= 1'b1;
			else if (status_read)
				tstp_flag <= 1'b0;
		end
	end

	always_comb
	begin
		sources = '0;
		sources[MB-1:0] = mailbox_ready | mailbox_aborted;
		sources[SR_ERRA] = !bus_off && !error_passive;
		sources[SR_WARN] = warn;
		sources[SR_ERRP] = error_passive && !bus_off;
		sources[SR_BOFF] = bus_off;
		sources[SR_SLEEP] = sleep_flag;
		sources[SR_WAKEUP] = wake_flag;
		sources[SR_TOVF] = tovf_flag;
		sources[SR_TSTP] = tstp_flag;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			status_register <= '0;
		else
			status_register <= sources;
	end

	// disable wins when both writes hit the same bit
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			interrupt_mask_register <= MASK_RESET;
		else
			interrupt_mask_register <= (interrupt_mask_register |
				interrupt_enable_register) &
				~interrupt_disable_register;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			irq <= 1'b0;
		else
			irq <= |(sources & interrupt_mask_register);
	end
endmodule
`default_nettype wire

// File: verif/can_pwr_properties.sv
// assertions on the power, overload and interrupt control ports
`timescale 1ns/100ps
`default_nettype none
module can_pwr_properties
	import can_pwr_pkg::*;
(
	// clock, reset and mode
	input wire logic sys_clk, rst, controller_enable, low_power_request,
	// bus, fault and mask write inputs
	input wire logic bit_tick, bus_rx, in_intermission, bus_off,
	input wire logic error_passive,
	input wire logic [1:0] intermission_bit,
	input wire logic [ERR_WIDTH-1:0] tx_err_count, rx_err_count,
	input wire logic [SR_WIDTH-1:0] interrupt_disable_register,
	// outputs
	input wire logic overload_start, overload_reactive, protocol_reset,
	input wire logic tx_allowed, rx_allowed, error_count_enable, irq,
	input wire logic [SR_WIDTH-1:0] status_register, interrupt_mask_register
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic [3:0] run;
	// saturates so a long idle bus cannot wrap back under eleven
	always_ff @(posedge sys_clk)
	begin
		if (rst || (bit_tick && !bus_rx))
			run <= 4'h0;
		else if (bit_tick && run != 4'hF)
			run <= run + 4'h1;
	end
	property p_mask;
		|interrupt_disable_register |=>
			(interrupt_mask_register & $past(interrupt_disable_register)) == '0;
	endproperty
	a_mask: assert property (p_mask) else $error("mask kept");
	property p_excl;
		!(status_register[SR_SLEEP] && status_register[SR_WAKEUP]);
	endproperty
	a_excl: assert property (p_excl) else $error("sleep and wake");
	property p_irq;
		$stable(status_register) && $stable(interrupt_mask_register) |->
			irq == |(status_register & interrupt_mask_register);
	endproperty
	a_irq: assert property (p_irq) else $error("irq wrong");
	property p_sleep;
		low_power_request && status_register[SR_SLEEP] |->
			!tx_allowed && !rx_allowed && !error_count_enable;
	endproperty
	a_sleep: assert property (p_sleep) else $error("active asleep");
	property p_reset;
		$rose(controller_enable) |-> protocol_reset;
	endproperty
	a_reset: assert property (p_reset) else $error("no reset");
	property p_wake;
		$rose(status_register[SR_WAKEUP]) |-> run >= 4'hB;
	endproperty
	a_wake: assert property (p_wake) else $error("early wake");
	property p_ovl;
		bit_tick && in_intermission && intermission_bit < 2'h2 && !bus_rx
			&& rx_allowed |=> overload_start && overload_reactive;
	endproperty
	a_ovl: assert property (p_ovl) else $error("no overload");
	property p_warn;
		!bus_off && !error_passive && (tx_err_count > WARN_LIMIT ||
			rx_err_count > WARN_LIMIT) |=> status_register[SR_WARN];
	endproperty
	a_warn: assert property (p_warn) else $error("no warning");
endmodule
`default_nettype wire

// File: verif/can_bus_model.sv
// bus side: one bit every DIV clocks, dominant only on command
`timescale 1ns/100ps
`default_nettype none
module can_bus_model #(
	parameter int DIV = 4
)(
	// clock and command
	input wire logic sys_clk,
	input wire logic dominant,
	// bit stream
	output var logic bit_tick = 1'h0,
	output var logic bus_rx = 1'h1
);
	int cnt = 0;
	// level held for the whole bit, recessive when idle
	always_ff @(posedge sys_clk)
	begin
		cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
		bit_tick <= cnt == DIV - 1;
		if (cnt == DIV - 1)
			bus_rx <= !dominant;
	end
endmodule
`default_nettype wire

// File: verif/tb.sv
// self-checking bench for the can power and interrupt control
`timescale 1ns/100ps
`default_nettype none
module tb;
	import can_pwr_pkg::*;
	logic sys_clk = 0, rst = 1, controller_enable = 0, autobaud_listen = 0;
	logic low_power_request = 0, overload_request_enable = 0, dominant = 0;
	logic status_read = 0, in_intermission = 0, last_eof_bit = 0;
	logic last_delim_bit = 0, is_receiver = 0, frame_in_progress = 0;
	logic frame_edge = 0, message_delivered = 0, tx_pending = 0;
	logic bus_off = 0, error_passive = 0, bit_tick, bus_rx, irq;
	logic [1:0] intermission_bit = 2'h1;
	logic [ERR_WIDTH-1:0] tx_err_count = '0, rx_err_count = '0;
	logic [15:0] mailbox_ready = '0, mailbox_aborted = '0, timestamp_register;
	logic [23:0] interrupt_enable_register = '0;
	logic [23:0] interrupt_disable_register = '0;
	logic [23:0] status_register, interrupt_mask_register;
	logic overload_start, overload_reactive, protocol_reset, tx_allowed;
	logic rx_allowed, mailboxes_active, error_count_enable, discard_frame;
	int n_errors = 0, comparisons = 0, n_ovl = 0, n_react = 0;
	logic [15:0] ts;
	typedef struct {logic [23:0] en, dis, mask; logic irq;} row_t;
	row_t rows [4] = '{'{24'h200000, '0, 24'h200000, 1'h1},
		'{'0, 24'h200000, '0, 1'h0}, '{24'hFFFFFF, 24'h010000, 24'hFEFFFF, 1'h1},
		'{24'h100000, 24'hFFFFFF, '0, 1'h0}};
	can_power_init_irq_control dut_u (.*);
	can_bus_model bus_u (.*);
	always #5 sys_clk = !sys_clk;
	always @(posedge sys_clk)
	begin
		if (overload_start === 1'h1)
			n_ovl++;
		if (overload_reactive === 1'h1)
			n_react++;
	end
	task automatic chk(string what, logic [23:0] seen, logic [23:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic ticks(int n);
		repeat (n)
			do @(posedge sys_clk); while (bit_tick !== 1'h1);
		#1;
	endtask
	// exactly one dominant bit, then room for the answer
	task automatic dom;
		ticks(1);
		dominant = 1;
		ticks(1);
		dominant = 0;
		cyc(2);
	endtask
	task automatic conclude;
		$display("comparisons %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		cyc(8);
		rst = 0;
		chk("sr", status_register, '0);
		chk("mask", interrupt_mask_register, '0);
		chk("tx", tx_allowed, 0);
		$display("end reset");
		controller_enable = 1;
		dom;
		ticks(10);
		cyc(3);
		chk("wake10", status_register[SR_WAKEUP], 0);
		ticks(1);
		cyc(3);
		chk("wake11", status_register[SR_WAKEUP], 1);
		chk("tx", tx_allowed, 1);
		foreach (rows[i])
		begin
			interrupt_enable_register = rows[i].en;
			interrupt_disable_register = rows[i].dis;
			cyc(1);
			interrupt_enable_register = '0;
			interrupt_disable_register = '0;
			cyc(3);
			chk("mask", interrupt_mask_register, rows[i].mask);
			chk("irq", irq, rows[i].irq);
		end
		tx_err_count = 9'h061;
		mailbox_ready = 16'h0004;
		mailbox_aborted = 16'h0100;
		cyc(2);
		chk("warn", status_register[17:16], 2'h3);
		chk("mbox", status_register[15:0], 16'h0104);
		tx_err_count = 9'h060;
		rx_err_count = 9'h061;
		error_passive = 1;
		cyc(2);
		chk("errs", status_register[18:16], 3'h4);
		error_passive = 0;
		bus_off = 1;
		cyc(2);
		chk("boff", status_register[19:16], 4'h8);
		bus_off = 0;
		frame_edge = 1;
		cyc(1);
		frame_edge = 0;
		cyc(1);
		chk("tstp", status_register[SR_TSTP], 1);
		ts = timestamp_register;
		status_read = 1;
		cyc(1);
		status_read = 0;
		cyc(1);
		chk("tstp", status_register[SR_TSTP], 0);
		frame_edge = 1;
		cyc(1);
		frame_edge = 0;
		chk("stamp", 24'(timestamp_register - ts), 24'h000004);
		$display("end status");
		in_intermission = 1;
		dom;
		chk("ovl1", 24'(n_ovl), 24'h000001);
		intermission_bit = 2'h2;
		dom;
		chk("ovl2", 24'(n_ovl), 24'h000001);
		in_intermission = 0;
		last_eof_bit = 1;
		is_receiver = 1;
		dom;
		chk("eof", 24'(n_ovl), 24'h000002);
		is_receiver = 0;
		dom;
		chk("eoftx", 24'(n_ovl), 24'h000002);
		last_eof_bit = 0;
		last_delim_bit = 1;
		dom;
		last_delim_bit = 0;
		chk("delim", 24'(n_ovl), 24'h000003);
		overload_request_enable = 1;
		message_delivered = 1;
		cyc(1);
		message_delivered = 0;
		ticks(2);
		cyc(2);
		chk("req", 24'(n_ovl), 24'h000004);
		chk("react", 24'(n_react), 24'h000003);
		$display("end overload");
		tx_pending = 1;
		low_power_request = 1;
		cyc(20);
		chk("drain", status_register[SR_SLEEP], 0);
		chk("draintx", tx_allowed, 1);
		tx_pending = 0;
		cyc(3);
		chk("sleep", status_register[21:20], 2'h1);
		chk("off", {tx_allowed, rx_allowed, mailboxes_active}, 0);
		chk("cnt", error_count_enable, 0);
		ticks(1);
		low_power_request = 0;
		frame_in_progress = 1;
		cyc(1);
		chk("discard", discard_frame, 1);
		frame_in_progress = 0;
		cyc(1);
		chk("discard", discard_frame, 0);
		ticks(10);
		cyc(3);
		chk("asleep10", status_register[21:20], 2'h1);
		ticks(1);
		cyc(3);
		chk("wake", status_register[21:20], 2'h2);
		chk("tx", tx_allowed, 1);
		autobaud_listen = 1;
		cyc(1);
		chk("abm", {tx_allowed, rx_allowed, error_count_enable}, 3'h2);
		autobaud_listen = 0;
		chk("tovf0", status_register[SR_TOVF], 0);
		cyc(1 << TIMER_WIDTH);
		chk("tovf", status_register[SR_TOVF], 1);
		status_read = 1;
		cyc(1);
		status_read = 0;
		cyc(1);
		chk("tovf", status_register[SR_TOVF], 0);
		$display("end power");
		conclude;
	end
	initial
	begin
		// one full timer wrap plus well under 2000 cycles of sequence
		#800000;
		n_errors++;
		conclude;
	end
endmodule
bind can_power_init_irq_control can_pwr_properties chk_u (.*);
`default_nettype wire
